/* File: rtl/pmkc_pkg.sv */
/*
  shared constants for the power mode key control block: register byte
  addresses, field positions, reset values, unlock keys and state codes.
  assumes an apb slave with 16-bit byte addresses and 32-bit data.
*/
package pmkc_pkg;

  // ------------------------------------------------------------------
  // bus widths
  // ------------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;

  // ------------------------------------------------------------------
  // register byte addresses
  // ------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] PM_CTRL_ADDR   = 16'h0a00;
  localparam logic [ADDR_W-1:0] PM_UNLOCK_ADDR = 16'h0a04;
  localparam logic [ADDR_W-1:0] LP_UNLOCK_ADDR = 16'h210c;
  localparam logic [ADDR_W-1:0] LP_CLKSEL_ADDR = 16'h2110;
  localparam logic [ADDR_W-1:0] LP_PDN_ADDR    = 16'h2114;

  // ------------------------------------------------------------------
  // widths, reset values and writable masks
  // ------------------------------------------------------------------
  localparam int PM_W     = 16;
  localparam int LP_KEY_W = 20;
  localparam int LP_PDN_W = 9;

  localparam logic [PM_W-1:0]     PM_CTRL_RST   = 16'h0001;
  localparam logic [PM_W-1:0]     PM_CTRL_MASK  = 16'hc00f;
  localparam logic [PM_W-1:0]     PM_UNLOCK_RST = 16'h0000;
  localparam logic [LP_KEY_W-1:0] LP_UNLOCK_RST = 20'h00000;
  localparam logic                LP_CLKSEL_RST = 1'b0;
  localparam logic [LP_PDN_W-1:0] LP_PDN_RST    = 9'h102;

  // ------------------------------------------------------------------
  // unlock keys
  // ------------------------------------------------------------------
  localparam logic [PM_W-1:0]     PM_KEY_FIRST  = 16'h4859;
  localparam logic [PM_W-1:0]     PM_KEY_SECOND = 16'hf27b;
  localparam logic [LP_KEY_W-1:0] LP_KEY        = 20'hc59d6;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int PM_RAMRET_BIT = 15;
  localparam int PM_ADCRET_BIT = 14;
  localparam int PM_SEQSLP_BIT = 3;
  localparam int PM_TMRSLP_BIT = 2;
  localparam int PM_MODE_MSB   = 1;
  localparam int PM_MODE_LSB   = 0;

  localparam int LP_CLKSEL_BIT = 0;

  localparam int LP_ALDO_BIT   = 8;
  localparam int LP_CMBUF_BIT  = 7;
  localparam int LP_REFBUF_BIT = 6;
  localparam int LP_ADCREP_BIT = 3;
  localparam int LP_ADCCNV_BIT = 2;
  localparam int LP_HSREF_BIT  = 1;
  localparam int LP_HFOSC_BIT  = 0;

  // ------------------------------------------------------------------
  // mode codes and key state
  // ------------------------------------------------------------------
  localparam logic [1:0] MODE_ACTIVE    = 2'b01;
  localparam logic [1:0] MODE_HIBERNATE = 2'b10;

  typedef enum logic [2:0] {
    PK_LOCKED = 3'b001,
    PK_HALF   = 3'b010,
    PK_OPEN   = 3'b100
  } pmkc_key_e;

endpackage : pmkc_pkg

/* File: rtl/pmkc_mode_decode.sv */
/*
  turns the stored power mode field and retention bits into registered
  power domain controls.
  assumes the mode field and retention bits come from flip-flops.
*/
`timescale 1ns/10ps
module pmkc_mode_decode (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] mode,
  input  wire logic       ram_ret,
  input  wire logic       adc_ret,
  output logic            core_powerdown,
  output logic            hsclk_powerdown,
  output logic            sram_powerdown,
  output logic            sram_retain,
  output logic            adc_switch_on,
  output logic            afe_powerdown
);
  import pmkc_pkg::*;

  logic hib;

  // reserved code 11 is treated as active so the core never sleeps on it
  assign hib = (mode == MODE_HIBERNATE);

  // ------------------------------------------------------------------
  // domain controls
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_powerdown  <= 1'b0;
      hsclk_powerdown <= 1'b0;
      sram_powerdown  <= 1'b0;
      sram_retain     <= 1'b0;
      adc_switch_on   <= 1'b1;
      afe_powerdown   <= 1'b0;
    end else begin
      core_powerdown  <= hib;
      hsclk_powerdown <= hib;
      sram_powerdown  <= hib;
      sram_retain     <= hib & ram_ret;
      adc_switch_on   <= ~hib | adc_ret;
      // low power dacs and references stay outside this domain
      afe_powerdown   <= hib;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  hib_core_off_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (mode == MODE_HIBERNATE) |=> (core_powerdown && hsclk_powerdown))
    else $error("hibernate did not power down core and fast clock");

  active_on_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (mode == MODE_ACTIVE) |=> (!core_powerdown && !sram_powerdown))
    else $error("active mode powered a domain down");

  ram_keep_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (hib && ram_ret) |=> sram_retain)
    else $error("ram not retained in hibernate");

  adc_sw_off_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (hib && !adc_ret) |=> !adc_switch_on)
    else $error("adc switch left on in hibernate");

endmodule : pmkc_mode_decode

/* File: rtl/pmkc_top.sv */
/*
  apb register block for key protected power mode control and the low
  power block power-down and clock select registers.
  assumes a single 100 mhz pclk, apb3 master, async active low reset.
*/
`timescale 1ns/10ps

// Function
// - block power-down bits 8, 1 and 0 written one power their block down; bits 7, 6, 3, 2 enable
// - block power-down bit 1 powers down the fast reference
// - low power key must be written first; locked writes are ignored
// - clock select bit 0 lets the sequencer go to 32 khz
// - clock select register shares the low power key guard
// - power mode bit 15 keeps ram contents during hibernate
// - power mode bit 14 keeps adc power switch on in hibernate
// - power mode bit 3 enables sequencer command autosleep
// - power mode bit 2 enables wake-up timer autosleep
// - mode field reads back the last value written while the key was open
// - mode 01 is active, all digital powered; 11 reserved
// - mode 10 hibernates core and fast clock, slow clock runs
// - hibernate powers down sram and most analog blocks
// - mode register opens after keys 4859 then f27b in order
// - any other register write before the mode write relocks
// - low power key of any other value locks its registers
// - clearing clock select bit 0 returns to 16 mhz oscillator
// - block bits: 8 ldo, 1 reference, 0 oscillator, 2/3 adc
module pmkc_top (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [pmkc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [pmkc_pkg::DATA_W-1:0] pwdata,
  output logic      [pmkc_pkg::DATA_W-1:0] prdata,
  output logic                             pready,
  output logic                             pslverr,
  output logic      [1:0]                  power_mode,
  output logic                             ram_retention_enable,
  output logic                             adc_switch_retention,
  output logic                             sequencer_autosleep_enable,
  output logic                             timer_autosleep_enable,
  output logic                             slow_sysclk_switch_enable,
  output logic                             analog_ldo_powerdown,
  output logic                             cm_buffer_enable,
  output logic                             ref_buffer_enable,
  output logic                             adc_repeat_enable,
  output logic                             adc_conversion_enable,
  output logic                             fast_reference_powerdown,
  output logic                             fast_oscillator_powerdown,
  output logic                             core_powerdown,
  output logic                             hsclk_powerdown,
  output logic                             sram_powerdown,
  output logic                             sram_retain,
  output logic                             adc_switch_on,
  output logic                             afe_powerdown
);
  import pmkc_pkg::*;

  // ------------------------------------------------------------------
  // storage
  // ------------------------------------------------------------------
  logic [PM_W-1:0]     pm_ctrl_reg;
  logic [PM_W-1:0]     pm_unlock_reg;
  logic [LP_KEY_W-1:0] lp_unlock_reg;
  logic                lp_clksel_reg;
  logic [LP_PDN_W-1:0] lp_pdn_reg;
  pmkc_key_e           key_reg;
  pmkc_key_e           key_next;
  logic [DATA_W-1:0]   prdata_reg;
  logic                pready_reg;
  logic                pslverr_reg;

  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  logic              access;
  logic              wr_fire;
  logic              hit_pm;
  logic              hit_pmkey;
  logic              hit_lpkey;
  logic              hit_clk;
  logic              hit_pdn;
  logic              hit_any;
  logic              lp_open;
  logic [DATA_W-1:0] rdata_next;

  assign access    = psel & penable;
  // a write lands only on the edge where pready is seen high
  assign wr_fire   = access & pready_reg & pwrite;
  assign hit_pm    = (paddr == PM_CTRL_ADDR);
  assign hit_pmkey = (paddr == PM_UNLOCK_ADDR);
  assign hit_lpkey = (paddr == LP_UNLOCK_ADDR);
  assign hit_clk   = (paddr == LP_CLKSEL_ADDR);
  assign hit_pdn   = (paddr == LP_PDN_ADDR);
  assign hit_any   = hit_pm | hit_pmkey | hit_lpkey | hit_clk | hit_pdn;
  // any stored value other than the key keeps both guarded registers shut
  assign lp_open   = (lp_unlock_reg == LP_KEY);

  // ------------------------------------------------------------------
  // apb handshake: one wait state, answer held for one cycle
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= '0;
    end else begin
      pready_reg  <= access & ~pready_reg;
      pslverr_reg <= access & ~pready_reg & ~hit_any;
      if (access && !pready_reg) begin
        prdata_reg <= pwrite ? '0 : rdata_next;
      end
    end
  end

  always_comb begin
    rdata_next = '0;
    unique case (1'b1)
      hit_pm:    rdata_next[PM_W-1:0] = pm_ctrl_reg;
      hit_pmkey: rdata_next[PM_W-1:0] = pm_unlock_reg;
      hit_lpkey: rdata_next[LP_KEY_W-1:0] = lp_unlock_reg;
      hit_clk:   rdata_next[LP_CLKSEL_BIT] = lp_clksel_reg;
      hit_pdn:   rdata_next[LP_PDN_W-1:0] = lp_pdn_reg;
      default:   rdata_next = '0;
    endcase
  end

  // ------------------------------------------------------------------
  // power mode key sequence
  // ------------------------------------------------------------------
  always_comb begin
    key_next = key_reg;
    if (wr_fire) begin
      if (hit_pmkey) begin
        if (pwdata[PM_W-1:0] == PM_KEY_FIRST) begin
          key_next = PK_HALF;
        end else if (key_reg == PK_HALF &&
                     pwdata[PM_W-1:0] == PM_KEY_SECOND) begin
          key_next = PK_OPEN;
        end else begin
          key_next = PK_LOCKED;
        end
      end else begin
        // the mode write itself closes the key as well
        key_next = PK_LOCKED;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_reg <= PK_LOCKED;
    end else begin
      key_reg <= key_next;
    end
  end

  // ------------------------------------------------------------------
  // power mode registers
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pm_ctrl_reg <= PM_CTRL_RST;
    end else if (wr_fire && hit_pm && key_reg == PK_OPEN) begin
      // reserved bits never store, so they read back as zero
      pm_ctrl_reg <= pwdata[PM_W-1:0] & PM_CTRL_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pm_unlock_reg <= PM_UNLOCK_RST;
    end else if (wr_fire && hit_pmkey) begin
      pm_unlock_reg <= pwdata[PM_W-1:0];
    end
  end

  // ------------------------------------------------------------------
  // low power registers behind their own key
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lp_unlock_reg <= LP_UNLOCK_RST;
    end else if (wr_fire && hit_lpkey) begin
      lp_unlock_reg <= pwdata[LP_KEY_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lp_clksel_reg <= LP_CLKSEL_RST;
    end else if (wr_fire && hit_clk && lp_open) begin
      lp_clksel_reg <= pwdata[LP_CLKSEL_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lp_pdn_reg <= LP_PDN_RST;
    end else if (wr_fire && hit_pdn && lp_open) begin
      // one write may switch several blocks at once
      lp_pdn_reg <= pwdata[LP_PDN_W-1:0];
    end
  end

  // ------------------------------------------------------------------
  // outputs, all taken from flip-flops
  // ------------------------------------------------------------------
  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  assign power_mode                 = pm_ctrl_reg[PM_MODE_MSB:PM_MODE_LSB];
  assign ram_retention_enable       = pm_ctrl_reg[PM_RAMRET_BIT];
  assign adc_switch_retention       = pm_ctrl_reg[PM_ADCRET_BIT];
  assign sequencer_autosleep_enable = pm_ctrl_reg[PM_SEQSLP_BIT];
  assign timer_autosleep_enable     = pm_ctrl_reg[PM_TMRSLP_BIT];
  assign slow_sysclk_switch_enable  = lp_clksel_reg;
  assign analog_ldo_powerdown       = lp_pdn_reg[LP_ALDO_BIT];
  assign cm_buffer_enable           = lp_pdn_reg[LP_CMBUF_BIT];
  assign ref_buffer_enable          = lp_pdn_reg[LP_REFBUF_BIT];
  assign adc_repeat_enable          = lp_pdn_reg[LP_ADCREP_BIT];
  assign adc_conversion_enable      = lp_pdn_reg[LP_ADCCNV_BIT];
  assign fast_reference_powerdown   = lp_pdn_reg[LP_HSREF_BIT];
  assign fast_oscillator_powerdown  = lp_pdn_reg[LP_HFOSC_BIT];

  pmkc_mode_decode u_decode (
    .clk             (pclk),
    .rst_n           (presetn),
    .mode            (pm_ctrl_reg[PM_MODE_MSB:PM_MODE_LSB]),
    .ram_ret         (pm_ctrl_reg[PM_RAMRET_BIT]),
    .adc_ret         (pm_ctrl_reg[PM_ADCRET_BIT]),
    .core_powerdown  (core_powerdown),
    .hsclk_powerdown (hsclk_powerdown),
    .sram_powerdown  (sram_powerdown),
    .sram_retain     (sram_retain),
    .adc_switch_on   (adc_switch_on),
    .afe_powerdown   (afe_powerdown)
  );

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence key_first_s;
    wr_fire && hit_pmkey && pwdata[PM_W-1:0] == PM_KEY_FIRST;
  endsequence

  sequence key_second_s;
    wr_fire && hit_pmkey && key_reg == PK_HALF &&
    pwdata[PM_W-1:0] == PM_KEY_SECOND;
  endsequence

  sequence apb_setup_s;
    psel && !penable;
  endsequence

  key_half_a: assert property (
    key_first_s |=> key_reg == PK_HALF)
    else $error("first key did not arm the mode register");

  key_pair_open_a: assert property (
    key_second_s |=> key_reg == PK_OPEN)
    else $error("key pair did not open the mode register");

  mode_write_a: assert property (
    (wr_fire && hit_pm && key_reg == PK_OPEN) |=>
    pm_ctrl_reg == ($past(pwdata[PM_W-1:0]) & PM_CTRL_MASK))
    else $error("open mode write not stored");

  mode_locked_a: assert property (
    (wr_fire && hit_pm && key_reg != PK_OPEN) |=> $stable(pm_ctrl_reg))
    else $error("locked mode register changed");

  other_relock_a: assert property (
    (wr_fire && !hit_pm && !hit_pmkey) |=> key_reg == PK_LOCKED)
    else $error("foreign write did not relock");

  mode_relock_a: assert property (
    (wr_fire && hit_pm) |=> key_reg == PK_LOCKED)
    else $error("mode write left key open");

  pdn_locked_a: assert property (
    (wr_fire && hit_pdn && !lp_open) |=> $stable(lp_pdn_reg))
    else $error("locked block power-down register changed");

  pdn_multi_a: assert property (
    (wr_fire && hit_pdn && lp_open) |=>
    lp_pdn_reg == $past(pwdata[LP_PDN_W-1:0]))
    else $error("block power-down write not stored");

  hsref_off_a: assert property (
    (wr_fire && hit_pdn && lp_open && pwdata[LP_HSREF_BIT]) |=>
    fast_reference_powerdown)
    else $error("fast reference not powered down");

  clk_locked_a: assert property (
    (wr_fire && hit_clk && !lp_open) |=> $stable(slow_sysclk_switch_enable))
    else $error("locked clock select changed");

  clk_return_a: assert property (
    (wr_fire && hit_clk && lp_open && !pwdata[LP_CLKSEL_BIT]) |=>
    !slow_sysclk_switch_enable)
    else $error("clock select did not return to fast oscillator");

  lp_badkey_a: assert property (
    (wr_fire && hit_lpkey && pwdata[LP_KEY_W-1:0] != LP_KEY) |=> !lp_open)
    else $error("wrong low power key left registers open");

  mode_readback_a: assert property (
    (pready && !pwrite && hit_pm && access) |->
    prdata[PM_MODE_MSB:PM_MODE_LSB] == power_mode)
    else $error("mode field read back wrong");

  apb_answer_a: assert property (
    apb_setup_s ##1 access |=> pready ##1 !pready)
    else $error("apb answer not one wait state");

endmodule : pmkc_top

/* File: sim/pmkc_top_bench.sv */
/*
  self-checking bench for pmkc_top: apb register traffic, both unlock
  keys and the power control pins.
  assumes one pready pulse per apb transfer and registered pin outputs.
*/
`timescale 1ns/10ps
module pmkc_top_bench;
  import pmkc_pkg::*;

  // ------------------------------------------------------------------
  // signals and expected state
  // ------------------------------------------------------------------
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  wire  [19:0]       pins;
  logic [32:0]       exp_q[$];
  logic [32:0]       note;
  logic [15:0]       m_pm;
  logic              m_cs;
  logic [8:0]        m_pdn;
  int                n_fail;
  int                check_count;

  pmkc_top dut_u (
    .pclk                       (pclk),
    .presetn                    (presetn),
    .psel                       (psel),
    .penable                    (penable),
    .pwrite                     (pwrite),
    .paddr                      (paddr),
    .pwdata                     (pwdata),
    .prdata                     (prdata),
    .pready                     (pready),
    .pslverr                    (pslverr),
    .power_mode                 (pins[19:18]),
    .afe_powerdown              (pins[17]),
    .adc_switch_on              (pins[16]),
    .sram_retain                (pins[15]),
    .sram_powerdown             (pins[14]),
    .hsclk_powerdown            (pins[13]),
    .core_powerdown             (pins[12]),
    .fast_oscillator_powerdown  (pins[11]),
    .fast_reference_powerdown   (pins[10]),
    .adc_conversion_enable      (pins[9]),
    .adc_repeat_enable          (pins[8]),
    .ref_buffer_enable          (pins[7]),
    .cm_buffer_enable           (pins[6]),
    .analog_ldo_powerdown       (pins[5]),
    .slow_sysclk_switch_enable  (pins[4]),
    .timer_autosleep_enable     (pins[3]),
    .sequencer_autosleep_enable (pins[2]),
    .adc_switch_retention       (pins[1]),
    .ram_retention_enable       (pins[0])
  );

  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  // ------------------------------------------------------------------
  // apb master: notes {pslverr, prdata} expected per transfer
  // ------------------------------------------------------------------
  task automatic xfer(input logic w, input logic [15:0] a,
                      input logic [31:0] d, input logic [32:0] e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    // no wait count assumed: only the watchdog ends a hung transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 33'h0);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [31:0] v);
    xfer(1'b0, a, 32'h0, {1'b0, v});
  endtask : rd

  task automatic pm_open;
    wr(PM_UNLOCK_ADDR, 32'(PM_KEY_FIRST));
    wr(PM_UNLOCK_ADDR, 32'(PM_KEY_SECOND));
  endtask : pm_open

  // pins settle on the write edge, domain outputs one edge later
  task automatic chk_pins;
    logic [19:0] e;
    logic        h;
    @(posedge pclk);
    @(negedge pclk);
    h = (m_pm[1:0] == MODE_HIBERNATE);
    e = {m_pm[1:0], h, ~h | m_pm[14], h & m_pm[15], h, h, h,
         m_pdn[0], m_pdn[1], m_pdn[2], m_pdn[3], m_pdn[6], m_pdn[7],
         m_pdn[8], m_cs, m_pm[2], m_pm[3], m_pm[14], m_pm[15]};
    check_count++;
    if (pins !== e) begin
      $display("[ERR] pins exp %h got %h", e, pins);
      n_fail++;
    end
  endtask : chk_pins

  // ------------------------------------------------------------------
  // response watcher
  // ------------------------------------------------------------------
  always @(negedge pclk) begin
    if (pready === 1'b1) begin
      check_count++;
      note = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h1ffffffff;
      if ({pslverr, prdata} !== note) begin
        $display("[ERR] apb exp %h got %h", note, {pslverr, prdata});
        n_fail++;
      end
    end
  end

  task automatic close_out;
    if (n_fail == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  // hang guard, far beyond the 83 transfers below
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    close_out();
  end

  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial begin
    int          i;
    logic [19:0] k;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    presetn = 1'b0;
    n_fail = 0;
    check_count = 0;
    m_pm = PM_CTRL_RST;
    m_cs = LP_CLKSEL_RST;
    m_pdn = LP_PDN_RST;
    void'($urandom(40256));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(PM_CTRL_ADDR, 32'h1);
    rd(PM_UNLOCK_ADDR, 32'h0);
    rd(LP_UNLOCK_ADDR, 32'h0);
    rd(LP_CLKSEL_ADDR, 32'h0);
    rd(LP_PDN_ADDR, 32'h102);
    chk_pins();
    wr(LP_PDN_ADDR, 32'h1fd);
    wr(LP_CLKSEL_ADDR, 32'h1);
    rd(LP_PDN_ADDR, 32'h102);
    rd(LP_CLKSEL_ADDR, 32'h0);
    wr(LP_UNLOCK_ADDR, 32'(LP_KEY));
    rd(LP_UNLOCK_ADDR, 32'(LP_KEY));
    for (i = 0; i < 9; i++) begin
      m_pdn = 9'h1 << i;
      wr(LP_PDN_ADDR, 32'(m_pdn));
      chk_pins();
    end
    for (i = 0; i < 4; i++) begin
      m_pdn = 9'($urandom);
      wr(LP_PDN_ADDR, 32'(m_pdn));
      rd(LP_PDN_ADDR, 32'(m_pdn));
      chk_pins();
    end
    m_cs = 1'b1;
    wr(LP_CLKSEL_ADDR, 32'h1);
    chk_pins();
    m_cs = 1'b0;
    wr(LP_CLKSEL_ADDR, 32'h0);
    chk_pins();
    m_cs = 1'b1;
    wr(LP_CLKSEL_ADDR, 32'h1);
    k = LP_KEY ^ 20'($urandom_range(1, 20'hfffff));
    wr(LP_UNLOCK_ADDR, 32'(k));
    wr(LP_CLKSEL_ADDR, 32'h0);
    wr(LP_PDN_ADDR, 32'h0);
    rd(LP_CLKSEL_ADDR, 32'h1);
    rd(LP_PDN_ADDR, 32'(m_pdn));
    wr(PM_CTRL_ADDR, 32'h2);
    rd(PM_CTRL_ADDR, 32'h1);
    pm_open();
    wr(PM_CTRL_ADDR, 32'hfffe);
    m_pm = 16'hc00e;
    rd(PM_CTRL_ADDR, 32'hc00e);
    chk_pins();
    wr(PM_CTRL_ADDR, 32'h1);
    rd(PM_CTRL_ADDR, 32'hc00e);
    pm_open();
    wr(LP_PDN_ADDR, 32'h0);
    wr(PM_CTRL_ADDR, 32'h1);
    rd(PM_CTRL_ADDR, 32'hc00e);
    pm_open();
    xfer(1'b1, 16'h0a08, 32'h1, {1'b1, 32'h0});
    xfer(1'b0, 16'h0a08, 32'h0, {1'b1, 32'h0});
    wr(PM_CTRL_ADDR, 32'h1);
    rd(PM_CTRL_ADDR, 32'hc00e);
    wr(PM_UNLOCK_ADDR, 32'(PM_KEY_SECOND));
    rd(PM_UNLOCK_ADDR, 32'(PM_KEY_SECOND));
    wr(PM_CTRL_ADDR, 32'h1);
    rd(PM_CTRL_ADDR, 32'hc00e);
    for (i = 0; i < 6; i++) begin
      m_pm = 16'h0;
      m_pm[1:0] = 2'(i % 3 + 1);
      m_pm[15] = i[1];
      m_pm[14] = i[2];
      m_pm[3:2] = 2'($urandom);
      pm_open();
      wr(PM_CTRL_ADDR, 32'(m_pm | 16'h3ff0));
      rd(PM_CTRL_ADDR, 32'(m_pm));
      chk_pins();
    end
    close_out();
  end

endmodule : pmkc_top_bench
